/* File: rtl/vapr_map.svh */
`ifndef VAPR_MAP_SVH
`define VAPR_MAP_SVH
`define VAPR_OPC1 3'h4
`define VAPR_CRN 4'hC
`define VAPR_CRM_G0 4'h8
`define VAPR_CRM_G1 4'h9
`define VAPR_CRM_CTRL 4'hB
`define VAPR_CRM_LR_FIRST 4'hC
`define VAPR_OPC2_HCR 3'h0
`define VAPR_OPC2_VTR 3'h1
`define VAPR_OPC2_MISR 3'h2
`define VAPR_OPC2_EISR 3'h3
`define VAPR_OPC2_ELRSR 3'h5
`define VAPR_OPC2_VMCR 3'h7
`define VAPR_PB5 2'h0
`define VAPR_PB6 2'h1
`define VAPR_PB7 2'h2
`define VAPR_FLAGS_RST 32'h0
`define VAPR_RDATA_ZERO 32'h0
`endif

/* File: rtl/vapr_pkg.sv */
package vapr_pkg;
  typedef enum logic [1:0] {
    VAPR_LVL_USER,
    VAPR_LVL_KERNEL,
    VAPR_LVL_HYP,
    VAPR_LVL_MONITOR
  } vapr_level_t;
  typedef enum logic [1:0] {
    VAPR_RESP_OK,
    VAPR_RESP_UNDEF,
    VAPR_RESP_TRAP_HYP,
    VAPR_RESP_OTHER
  } vapr_resp_t;
endpackage : vapr_pkg

/* File: rtl/vapr_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "vapr_map.svh"
module vapr_regs
  import vapr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Configuration and controls from the core
  input wire logic [1:0] impl_prio_bits_i,
  input wire logic hyp_present_i,
  input wire logic hyp_sysreg_en_i,
  input wire logic mon_sysreg_en_i,
  input wire logic trap_coproc_twelve_i,
  // Coprocessor access request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [2:0] req_opc1_i,
  input wire logic [3:0] req_crn_i,
  input wire logic [3:0] req_crm_i,
  input wire logic [2:0] req_opc2_i,
  input wire logic [31:0] req_wdata_i,
  input wire vapr_level_t req_level_i,
  input wire logic req_nonsecure_i,
  // Activation and deactivation events
  input wire logic act_valid_i,
  input wire logic act_group_i,
  input wire logic [7:0] act_prio_i,
  input wire logic deact_valid_i,
  input wire logic deact_group_i,
  input wire logic [7:0] deact_prio_i,
  // Access answer
  output logic resp_valid_o,
  output vapr_resp_t resp_kind_o,
  output logic [31:0] resp_rdata_o
);

  logic [1:0] pbits_ff;
  logic [31:0] flags_ff [2][4];
  logic resp_valid_ff;
  vapr_resp_t resp_kind_ff;
  logic [31:0] resp_rdata_ff;

  logic [6:0] act_map;
  logic [6:0] deact_map;
  logic hit_g0;
  logic hit_g1;
  logic hit_ap;
  logic hit_ctl;
  logic ctl_ro;
  logic hit_lr;
  logic [1:0] req_idx;
  logic [31:0] sel_word;
  vapr_resp_t nxt_kind;
  logic [31:0] nxt_rdata;
  logic sw_we;

  // Returns {register index, bit index} for a priority
  function automatic logic [6:0] map_prio(input logic [7:0] prio,
                                          input logic [1:0] pb);
    logic [6:0] res;
    res = {2'h0, prio[7:3]};
    if (pb == `VAPR_PB6) begin
      res = {1'b0, prio[7], prio[6:2]};
    end else if (pb == `VAPR_PB7) begin
      res = {prio[7:6], prio[5:1]};
    end
    return res;
  endfunction : map_prio

  function automatic logic reg_present(input logic [1:0] idx,
                                       input logic [1:0] pb);
    logic ok;
    ok = (idx == 2'h0);
    if (pb == `VAPR_PB6) begin
      ok = (idx[1] == 1'b0);
    end else if (pb == `VAPR_PB7) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : reg_present

  // Strap held steady through reset, caught while reset is high
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pbits_ff <= impl_prio_bits_i;
    end
  end

  assign act_map = map_prio(act_prio_i, pbits_ff);
  assign deact_map = map_prio(deact_prio_i, pbits_ff);

  // Access decode
  always_comb begin
    hit_g0 = 1'b0;
    hit_g1 = 1'b0;
    hit_ctl = 1'b0;
    hit_lr = 1'b0;
    if (req_opc1_i == `VAPR_OPC1 && req_crn_i == `VAPR_CRN) begin
      if (req_crm_i == `VAPR_CRM_G0) begin
        hit_g0 = !req_opc2_i[2];
      end else if (req_crm_i == `VAPR_CRM_G1) begin
        hit_g1 = !req_opc2_i[2];
      end else if (req_crm_i == `VAPR_CRM_CTRL) begin
        hit_ctl = req_opc2_i == `VAPR_OPC2_HCR || req_opc2_i == `VAPR_OPC2_VTR ||
                  req_opc2_i == `VAPR_OPC2_MISR || req_opc2_i == `VAPR_OPC2_EISR ||
                  req_opc2_i == `VAPR_OPC2_ELRSR ||
                  req_opc2_i == `VAPR_OPC2_VMCR;
      end else if (req_crm_i >= `VAPR_CRM_LR_FIRST) begin
        hit_lr = 1'b1;
      end
    end
  end

  assign hit_ap = hit_g0 || hit_g1;
  assign req_idx = req_opc2_i[1:0];
  assign ctl_ro = hit_ctl && (req_opc2_i == `VAPR_OPC2_VTR ||
                  req_opc2_i == `VAPR_OPC2_MISR ||
                  req_opc2_i == `VAPR_OPC2_EISR ||
                  req_opc2_i == `VAPR_OPC2_ELRSR);
  assign sel_word = flags_ff[hit_g1][req_idx];

  // Answer selection; trap outranks the enable checks
  always_comb begin
    nxt_kind = VAPR_RESP_OK;
    nxt_rdata = `VAPR_RDATA_ZERO;
    if (!hit_ap && !hit_ctl && !hit_lr) begin
      nxt_kind = VAPR_RESP_UNDEF;
    end else if (req_level_i == VAPR_LVL_KERNEL && req_nonsecure_i &&
                 hyp_present_i && trap_coproc_twelve_i) begin
      nxt_kind = VAPR_RESP_TRAP_HYP;
    end else if (req_level_i == VAPR_LVL_USER ||
                 req_level_i == VAPR_LVL_KERNEL) begin
      nxt_kind = VAPR_RESP_UNDEF;
    end else if (req_level_i == VAPR_LVL_HYP && !hyp_sysreg_en_i) begin
      nxt_kind = VAPR_RESP_UNDEF;
    end else if (req_level_i == VAPR_LVL_MONITOR && req_nonsecure_i &&
                 !mon_sysreg_en_i) begin
      nxt_kind = VAPR_RESP_UNDEF;
    end else if (hit_ctl || hit_lr) begin
      // Owned by neighbouring logic; only a write to a read-only one fails
      nxt_kind = (req_write_i && ctl_ro) ? VAPR_RESP_UNDEF
                                        : VAPR_RESP_OTHER;
    end else if (!hyp_present_i) begin
      nxt_kind = VAPR_RESP_OK;
    end else if (!reg_present(req_idx, pbits_ff)) begin
      nxt_kind = VAPR_RESP_UNDEF;
    end else if (!req_write_i) begin
      nxt_rdata = sel_word;
    end
  end

  assign sw_we = req_valid_i && req_write_i && hit_ap && hyp_present_i &&
                 nxt_kind == VAPR_RESP_OK;

  // Flag storage; hardware activation wins over any same-cycle clear
  for (genvar g = 0; g < 2; g++) begin : g_grp
    for (genvar r = 0; r < 4; r++) begin : g_reg
      logic [31:0] set_mask;
      logic [31:0] clr_mask;
      always_comb begin
        set_mask = `VAPR_FLAGS_RST;
        clr_mask = `VAPR_FLAGS_RST;
        if (act_valid_i && act_group_i == g[0] && act_map[6:5] == r[1:0]) begin
          set_mask[act_map[4:0]] = 1'b1;
        end
        if (deact_valid_i && deact_group_i == g[0] &&
            deact_map[6:5] == r[1:0]) begin
          clr_mask[deact_map[4:0]] = 1'b1;
        end
      end
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          flags_ff[g][r] <= `VAPR_FLAGS_RST;
        end else if (sw_we && hit_g1 == g[0] && req_idx == r[1:0]) begin
          flags_ff[g][r] <= (req_wdata_i & ~clr_mask) | set_mask;
        end else begin
          flags_ff[g][r] <= (flags_ff[g][r] & ~clr_mask) | set_mask;
        end
      end
    end
  end

  // Answer register, one cycle after the request
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      resp_valid_ff <= 1'b0;
      resp_kind_ff <= VAPR_RESP_OK;
      resp_rdata_ff <= `VAPR_RDATA_ZERO;
    end else begin
      resp_valid_ff <= req_valid_i;
      if (req_valid_i) begin
        resp_kind_ff <= nxt_kind;
        resp_rdata_ff <= nxt_rdata;
      end
    end
  end

  assign resp_valid_o = resp_valid_ff;
  assign resp_kind_o = resp_kind_ff;
  assign resp_rdata_o = resp_rdata_ff;

  property p_reset_clear;
    @(posedge clk_sys_i) disable iff (reset_i)
    $fell(reset_i) |-> (flags_ff[0][0] == `VAPR_FLAGS_RST &&
      flags_ff[0][3] == `VAPR_FLAGS_RST && flags_ff[1][0] == `VAPR_FLAGS_RST &&
      flags_ff[1][3] == `VAPR_FLAGS_RST);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("flags not clear after reset");

  property p_act_g0;
    @(posedge clk_sys_i) disable iff (reset_i)
    act_valid_i && !act_group_i |=>
      flags_ff[0][$past(act_map[6:5])][$past(act_map[4:0])];
  endproperty
  a_act_g0: assert property (p_act_g0)
    else $error("group 0 activation not recorded");

  property p_act_g1;
    @(posedge clk_sys_i) disable iff (reset_i)
    act_valid_i && act_group_i |=>
      flags_ff[1][$past(act_map[6:5])][$past(act_map[4:0])];
  endproperty
  a_act_g1: assert property (p_act_g1)
    else $error("group 1 activation not recorded");

  property p_map5;
    @(posedge clk_sys_i) disable iff (reset_i)
    pbits_ff == `VAPR_PB5 |-> act_map == {2'h0, act_prio_i[7:3]};
  endproperty
  a_map5: assert property (p_map5)
    else $error("five-bit mapping wrong");

  property p_map6;
    @(posedge clk_sys_i) disable iff (reset_i)
    pbits_ff == `VAPR_PB6 |-> act_map[6:5] == {1'b0, act_prio_i[7]} &&
      act_map[4:0] == act_prio_i[6:2];
  endproperty
  a_map6: assert property (p_map6)
    else $error("six-bit mapping wrong");

  property p_map7;
    @(posedge clk_sys_i) disable iff (reset_i)
    pbits_ff == `VAPR_PB7 |-> act_map == {act_prio_i[7:6], act_prio_i[5:1]};
  endproperty
  a_map7: assert property (p_map7)
    else $error("seven-bit mapping wrong");

  property p_absent;
    @(posedge clk_sys_i) disable iff (reset_i)
    req_valid_i && hit_ap && req_level_i == VAPR_LVL_HYP && hyp_sysreg_en_i &&
      hyp_present_i && req_idx[1] && pbits_ff != `VAPR_PB7
      |=> resp_valid_o && resp_kind_o == VAPR_RESP_UNDEF;
  endproperty
  a_absent: assert property (p_absent)
    else $error("absent register not undefined");

  property p_raz;
    @(posedge clk_sys_i) disable iff (reset_i)
    req_valid_i && hit_ap && !hyp_present_i &&
      req_level_i == VAPR_LVL_MONITOR && (!req_nonsecure_i || mon_sysreg_en_i)
      |=> resp_kind_o == VAPR_RESP_OK && resp_rdata_o == `VAPR_RDATA_ZERO;
  endproperty
  a_raz: assert property (p_raz)
    else $error("monitor access without hypervisor not zero");

  property p_read;
    @(posedge clk_sys_i) disable iff (reset_i)
    req_valid_i && !req_write_i && hit_ap && nxt_kind == VAPR_RESP_OK &&
      hyp_present_i |=> resp_rdata_o == $past(sel_word);
  endproperty
  a_read: assert property (p_read)
    else $error("read data does not match register");

  property p_ctrl_ro;
    @(posedge clk_sys_i) disable iff (reset_i)
    req_valid_i && req_write_i && ctl_ro && req_level_i == VAPR_LVL_HYP &&
      hyp_sysreg_en_i |=> resp_kind_o == VAPR_RESP_UNDEF;
  endproperty
  a_ctrl_ro: assert property (p_ctrl_ro)
    else $error("write to read-only control accepted");

  property p_hyp_dis;
    @(posedge clk_sys_i) disable iff (reset_i)
    req_valid_i && hit_ap && req_level_i == VAPR_LVL_HYP && !hyp_sysreg_en_i
      |=> resp_valid_o && resp_kind_o == VAPR_RESP_UNDEF;
  endproperty
  a_hyp_dis: assert property (p_hyp_dis)
    else $error("disabled hypervisor access not undefined");

  property p_trap;
    @(posedge clk_sys_i) disable iff (reset_i)
    req_valid_i && hit_ap && req_level_i == VAPR_LVL_KERNEL &&
      req_nonsecure_i && hyp_present_i && trap_coproc_twelve_i
      |=> resp_kind_o == VAPR_RESP_TRAP_HYP;
  endproperty
  a_trap: assert property (p_trap)
    else $error("kernel access not trapped");

  // A lone deactivation must drop its flag; activation would win instead
  property p_deact;
    @(posedge clk_sys_i) disable iff (reset_i)
    deact_valid_i && !act_valid_i |=>
      !flags_ff[$past(deact_group_i)][$past(deact_map[6:5])][$past(deact_map[4:0])];
  endproperty
  a_deact: assert property (p_deact)
    else $error("deactivated flag still set");

  property p_write;
    @(posedge clk_sys_i) disable iff (reset_i)
    sw_we && !act_valid_i && !deact_valid_i |=>
      flags_ff[$past(hit_g1)][$past(req_idx)] == $past(req_wdata_i);
  endproperty
  a_write: assert property (p_write)
    else $error("written word not stored");

  property p_cov_write;
    @(posedge clk_sys_i) disable iff (reset_i)
    sw_we && hit_g1;
  endproperty
  c_cov_write: cover property (p_cov_write);

  property p_cov_set_clr;
    @(posedge clk_sys_i) disable iff (reset_i)
    act_valid_i && deact_valid_i && act_prio_i == deact_prio_i;
  endproperty
  c_cov_set_clr: cover property (p_cov_set_clr);

  property p_cov_trap;
    @(posedge clk_sys_i) disable iff (reset_i)
    resp_valid_o && resp_kind_o == VAPR_RESP_TRAP_HYP;
  endproperty
  c_cov_trap: cover property (p_cov_trap);

  property p_cov_top_reg;
    @(posedge clk_sys_i) disable iff (reset_i)
    act_valid_i && act_map[6:5] == 2'h3;
  endproperty
  c_cov_top_reg: cover property (p_cov_top_reg);

endmodule : vapr_regs
`default_nettype wire

/* File: dv/vapr_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module vapr_core_model
  import vapr_pkg::*;
(
  // Clock and answer
  input wire logic clk_sys_i,
  input wire logic resp_valid_i,
  input wire vapr_resp_t resp_kind_i,
  input wire logic [31:0] resp_rdata_i,
  // Request
  output logic req_valid_o,
  output logic req_write_o,
  output logic [2:0] req_opc1_o,
  output logic [3:0] req_crn_o,
  output logic [3:0] req_crm_o,
  output logic [2:0] req_opc2_o,
  output logic [31:0] req_wdata_o,
  output vapr_level_t req_level_o,
  output logic req_nonsecure_o
);
  task automatic put(input logic [46:0] f);
    {req_write_o, req_opc1_o, req_crn_o, req_crm_o, req_opc2_o, req_wdata_o} = f;
  endtask : put
  initial begin
    req_valid_o = 1'b0;
    put(47'h0);
    req_level_o = VAPR_LVL_USER;
    req_nonsecure_o = 1'b0;
  end
  task automatic access(input logic wr, input logic [3:0] crm, input logic [2:0] opc2,
      input logic [31:0] wd, input vapr_level_t lvl, input logic ns,
      output vapr_resp_t kind, output logic [31:0] rd, output logic done);
    logic [46:0] f;
    f = {wr, 3'h4, 4'hC, crm, opc2, wd};
    @(posedge clk_sys_i);
    #1;
    req_valid_o = 1'b1;
    put(f);
    req_level_o = lvl;
    req_nonsecure_o = ns;
    @(posedge clk_sys_i);
    #1;
    // Answer registered at the taking edge
    done = resp_valid_i;
    kind = resp_kind_i;
    rd = resp_rdata_i;
    req_valid_o = 1'b0;
    // Idle fields flip, so stale values are never mistaken for a request
    put(~f);
  endtask : access
  task automatic restore(input logic [31:0] d [2][4], input int nr, output int bad);
    vapr_resp_t k;
    logic [31:0] rd;
    logic done;
    bad = 0;
    // Group 0 set first, then group 1
    for (int g = 0; g < 2; g++) begin
      for (int n = 0; n < nr; n++) begin
        access(1'b1, {3'h4, g[0]}, 3'(n), d[g][n], VAPR_LVL_HYP, 1'b0, k, rd, done);
        bad += (done === 1'b1 && k === VAPR_RESP_OK) ? 0 : 1;
      end
    end
  endtask : restore
endmodule : vapr_core_model
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench
  import vapr_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] impl_prio_bits_i = 2'h0;
  logic hyp_present_i = 1'b1;
  logic hyp_sysreg_en_i = 1'b1;
  logic mon_sysreg_en_i = 1'b1;
  logic trap_coproc_twelve_i = 1'b0;
  logic act_valid_i = 1'b0;
  logic act_group_i = 1'b0;
  logic deact_valid_i = 1'b0;
  logic deact_group_i = 1'b0;
  logic [7:0] act_prio_i = 8'h00;
  logic [7:0] deact_prio_i = 8'h00;
  logic req_valid_i, req_write_i, req_nonsecure_i, resp_valid_o;
  logic [2:0] req_opc1_i, req_opc2_i;
  logic [3:0] req_crn_i, req_crm_i;
  logic [31:0] req_wdata_i, resp_rdata_o;
  vapr_level_t req_level_i;
  vapr_resp_t resp_kind_o;
  int fail_count = 0;
  int comparisons = 0;
  int seed = 32'h0b32e4cf;
  int nr;
  logic [31:0] exp_flags [2][4];
  always #2 clk_sys_i = ~clk_sys_i;
  vapr_regs i_vapr_regs (.clk_sys_i, .reset_i, .impl_prio_bits_i, .hyp_present_i,
    .hyp_sysreg_en_i, .mon_sysreg_en_i, .trap_coproc_twelve_i, .req_valid_i, .req_write_i,
    .req_opc1_i, .req_crn_i, .req_crm_i, .req_opc2_i, .req_wdata_i, .req_level_i,
    .req_nonsecure_i, .act_valid_i, .act_group_i, .act_prio_i, .deact_valid_i,
    .deact_group_i, .deact_prio_i, .resp_valid_o, .resp_kind_o, .resp_rdata_o);
  vapr_core_model i_vapr_core_model (.clk_sys_i, .resp_valid_i(resp_valid_o),
    .resp_kind_i(resp_kind_o), .resp_rdata_i(resp_rdata_o), .req_valid_o(req_valid_i),
    .req_write_o(req_write_i), .req_opc1_o(req_opc1_i), .req_crn_o(req_crn_i),
    .req_crm_o(req_crm_i), .req_opc2_o(req_opc2_i), .req_wdata_o(req_wdata_i),
    .req_level_o(req_level_i), .req_nonsecure_o(req_nonsecure_i));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %0s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [6:0] loc(input logic [1:0] pb, input logic [7:0] p);
    case (pb)
      2'h1: return {1'b0, p[7], p[6:2]};
      2'h2: return {p[7:6], p[5:1]};
      default: return {2'h0, p[7:3]};
    endcase
  endfunction : loc
  task automatic acc(input logic wr, input logic [3:0] crm, input logic [2:0] opc2,
      input logic [31:0] wd, input vapr_level_t lvl, input logic ns,
      input vapr_resp_t ek, input logic [31:0] erd);
    vapr_resp_t k;
    logic [31:0] rd;
    logic done;
    i_vapr_core_model.access(wr, crm, opc2, wd, lvl, ns, k, rd, done);
    check("answer", {31'h0, done}, 32'h1);
    if (done !== 1'b1) begin
      report_and_stop();
    end else begin
      check("kind", {30'h0, k}, {30'h0, ek});
      check("rdata", rd, erd);
    end
  endtask : acc
  task automatic rd_ap(input logic g, input logic [1:0] n);
    if (n < nr) begin
      acc(1'b0, {3'h4, g}, {1'b0, n}, 32'h0, VAPR_LVL_HYP, 1'b0, VAPR_RESP_OK,
        exp_flags[g][n]);
    end else begin
      acc(1'b0, {3'h4, g}, {1'b0, n}, 32'h0, VAPR_LVL_HYP, 1'b0, VAPR_RESP_UNDEF,
        32'h0);
    end
  endtask : rd_ap
  task automatic ev(input logic set, input logic g, input logic [7:0] p);
    logic [6:0] l;
    l = loc(impl_prio_bits_i, p);
    @(posedge clk_sys_i);
    #1;
    if (set) begin
      {act_valid_i, act_group_i, act_prio_i} = {1'b1, g, p};
    end else begin
      {deact_valid_i, deact_group_i, deact_prio_i} = {1'b1, g, p};
    end
    exp_flags[g][l[6:5]][l[4:0]] = set;
    @(posedge clk_sys_i);
    #1;
    act_valid_i = 1'b0;
    deact_valid_i = 1'b0;
    {act_prio_i, deact_prio_i} = ~{p, p};
    rd_ap(g, l[6:5]);
  endtask : ev
  // Clear alone for one edge, then clear and set together: set must win
  task automatic ev_both(input logic g, input logic [7:0] p);
    @(posedge clk_sys_i);
    #1;
    {deact_valid_i, deact_group_i, deact_prio_i} = {1'b1, g, p};
    ev(1'b1, g, p);
  endtask : ev_both
  task automatic do_reset(input logic [1:0] pb);
    reset_i = 1'b1;
    impl_prio_bits_i = pb;
    // Strap value 3 is reserved and behaves as five bits
    nr = (pb == 2'h3) ? 1 : 1 << pb;
    exp_flags = '{default: 32'h0};
    repeat (3) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
  endtask : do_reset
  initial begin
    logic [7:0] p;
    logic [31:0] d [2][4];
    int bad;
    for (int pb = 0; pb < 4; pb++) begin
      do_reset(2'(pb));
      for (int n = 0; n < 4; n++) begin
        rd_ap(1'b0, 2'(n));
        rd_ap(1'b1, 2'(n));
      end
      ev(1'b1, 1'b0, 8'h7F);
      ev(1'b1, 1'b1, 8'hFE);
      ev_both(1'b0, 8'h40);
      repeat (16) begin
        p = 8'($random(seed));
        // Group follows top bit so levels never overlap across groups
        ev(1'b1, p[7], p);
        if (p[0]) ev(1'b0, p[7], p);
      end
      for (int n = 0; n < 4; n++) begin
        d[0][n] = $random(seed);
        d[1][n] = ~d[0][n];
        if (n < nr) exp_flags[0][n] = d[0][n];
        if (n < nr) exp_flags[1][n] = d[1][n];
      end
      i_vapr_core_model.restore(d, nr, bad);
      check("restore", 32'(bad), 32'h0);
      if (nr < 4) acc(1'b1, 4'h8, 3'(nr), 32'h1, VAPR_LVL_HYP, 1'b0, VAPR_RESP_UNDEF, 32'h0);
      for (int n = 0; n < 4; n++) begin
        rd_ap(1'b0, 2'(n));
        rd_ap(1'b1, 2'(n));
      end
      hyp_sysreg_en_i = 1'b0;
      acc(1'b1, 4'h8, 3'h0, 32'hFFFFFFFF, VAPR_LVL_HYP, 1'b0, VAPR_RESP_UNDEF, 32'h0);
      hyp_sysreg_en_i = 1'b1;
      mon_sysreg_en_i = 1'b0;
      acc(1'b0, 4'h9, 3'h0, 32'h0, VAPR_LVL_MONITOR, 1'b1, VAPR_RESP_UNDEF, 32'h0);
      acc(1'b0, 4'h9, 3'h0, 32'h0, VAPR_LVL_MONITOR, 1'b0, VAPR_RESP_OK, exp_flags[1][0]);
      mon_sysreg_en_i = 1'b1;
      trap_coproc_twelve_i = 1'b1;
      acc(1'b0, 4'h8, 3'h0, 32'h0, VAPR_LVL_KERNEL, 1'b1, VAPR_RESP_TRAP_HYP, 32'h0);
      trap_coproc_twelve_i = 1'b0;
      acc(1'b0, 4'h8, 3'h0, 32'h0, VAPR_LVL_KERNEL, 1'b1, VAPR_RESP_UNDEF, 32'h0);
      acc(1'b0, 4'hB, 3'h0, 32'h0, VAPR_LVL_HYP, 1'b0, VAPR_RESP_OTHER, 32'h0);
      acc(1'b1, 4'hB, 3'h1, 32'h0, VAPR_LVL_HYP, 1'b0, VAPR_RESP_UNDEF, 32'h0);
      acc(1'b0, 4'hF, 3'h7, 32'h0, VAPR_LVL_HYP, 1'b0, VAPR_RESP_OTHER, 32'h0);
      hyp_present_i = 1'b0;
      acc(1'b0, 4'h8, 3'h0, 32'h0, VAPR_LVL_MONITOR, 1'b1, VAPR_RESP_OK, 32'h0);
      acc(1'b1, 4'h8, 3'h0, 32'hFFFFFFFF, VAPR_LVL_MONITOR, 1'b1, VAPR_RESP_OK, 32'h0);
      hyp_present_i = 1'b1;
      rd_ap(1'b0, 2'h0);
      $display("test strap %0d done", pb);
    end
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
